/* reset_cause_map.svh */
`ifndef RESET_CAUSE_MAP_SVH
`define RESET_CAUSE_MAP_SVH

// Register offsets on the plain register port
`define OFS_CAUSE_STATUS 4'h0
`define OFS_PROTECT_LO 4'h1
`define OFS_PROTECT_HI 4'h2
`define OFS_PROTECT_CTRL 4'h3

// Field positions in the reset-cause status register
`define BIT_TRAP_CONFLICT 15
`define BIT_ILLEGAL_COND 14
`define BIT_CONFIG_MISMATCH 9
`define BIT_EXTERNAL_PIN 7
`define BIT_SOFTWARE_RESET 6
`define BIT_WATCHDOG_TIMEOUT 4
`define BIT_SLEEP 3
`define BIT_IDLE 2
`define BIT_BROWNOUT 1
`define BIT_POWER_ON 0

// Implemented flag bits; the rest read as zero
`define CAUSE_IMPL_MASK 16'hC2DF
// Flags that power-on and brown-out clear (external pin: power-on only)
`define CAUSE_BROWNOUT_CLEAR_MASK 16'hC25C
`define CAUSE_POR_CLEAR_MASK 16'hC2DC
// Power-on state: power-on and brown-out flags set
`define CAUSE_RESET_VALUE 16'h0003
`define PROTECT_LO_RESET 16'h0000
`define PROTECT_HI_RESET 16'h0000

// Opcode and trap figures
`define ILLEGAL_OPCODE_UPPER 8'h3F
`define HARD_TRAP_LOW 4'hD
`define HARD_TRAP_HIGH 4'hF
`define TRAP_ADDRESS_ERROR 4'hD
`define TRAP_OSC_FAILURE 4'hE
`define TRAP_NONE 4'h0

// Shadow store and working register figures
`define SHADOW_DEPTH 16
`define WREG_COUNT 15

// System reset pulse length in instruction cycles
`define RESET_PULSE_CYCLES 4'h1

`endif

/* reset_cause_pkg.sv */
package reset_cause_pkg;
    typedef logic [15:0] word_t;
    typedef logic [3:0] prio_t;
    typedef logic [3:0] index_t;
endpackage

/* shadow_store.sv */
`timescale 1ns/100ps
`include "reset_cause_map.svh"

module shadow_store
    import reset_cause_pkg::*;
(
    // Clock
    input wire logic clk,
    // Write side
    input wire logic wr_en,
    input wire index_t wr_index,
    input wire word_t wr_data,
    // Read side, data registered
    input wire index_t rd_index,
    output word_t rd_data_q
);

    word_t mem_q [`SHADOW_DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_index] <= wr_data;
        end
        rd_data_q <= mem_q[rd_index];
    end

endmodule

/* reset_cause_logger.sv */
// Summary of operation
// - Watchdog time-out when awake drives system reset; clock source kept.
// - Watchdog time-out in sleep or idle only wakes the core.
// - Watchdog time-out sets status bit 4.
// - Lower hard trap during higher trap service causes a reset.
// - Hard traps are priorities 13 to 15; address 13, oscillator 14.
// - Trap conflict reset sets status bit 15.
// - Pin-select registers are compared to shadows; mismatch resets.
// - Shadow mismatch reset sets status bit 9.
// - Illegal opcode, uninitialised register or security reset sets bit 14.
// - Fetched opcode with upper byte 3Fh is illegal and resets.
// - Working registers but stack pointer start unset; pointer use resets.
// - Flow change into restricted protected location resets.
// - Program flow: call, jump, return, branch; vector flow: vector load.
// - Watchdog flag clears on power-save, watchdog clear, supply resets.
// - Illegal-condition flag survives resets except power-on and brown-out.
// - Power-on and brown-out both set status bit 1.
// - Software may set and clear every flag by writing.
// - Reset instruction sets bit 6; reset released next cycle, clock kept.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps
`include "reset_cause_map.svh"

module reset_cause_logger
    import reset_cause_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst,
    // Supply supervisor and pin events
    input wire logic power_on_event,
    input wire logic brownout_event,
    input wire logic external_pin_event,
    // Watchdog and power modes
    input wire logic watchdog_timeout,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic power_save_instruction,
    input wire logic power_save_sleep,
    input wire logic watchdog_clear_instruction,
    input wire logic software_reset_instruction,
    // Trap controller
    input wire logic trap_request,
    input wire prio_t trap_priority,
    input wire logic trap_return,
    // Pin-select control registers
    input wire logic pps_write,
    input wire index_t pps_index,
    input wire word_t pps_wdata,
    input wire word_t pps_live_data,
    // Instruction fetch and working registers
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_upper,
    input wire logic wreg_write,
    input wire index_t wreg_write_index,
    input wire logic wreg_pointer_use,
    input wire index_t wreg_pointer_index,
    // Program counter reloads
    input wire logic program_flow_change,
    input wire logic vector_flow_change,
    input wire word_t flow_target,
    // Register port
    input wire index_t reg_addr,
    input wire word_t reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output word_t reg_rdata_q,
    // To the core
    output logic system_reset_q,
    output logic watchdog_wake_q,
    output index_t pps_scan_index_q
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic is_hard_trap(input prio_t p);
        is_hard_trap = (p >= `HARD_TRAP_LOW) && (p <= `HARD_TRAP_HIGH);
    endfunction

    function automatic logic reg_hit(input index_t a, input index_t ofs);
        reg_hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State

    word_t cause_q;
    word_t cause_d;
    word_t protect_lo_q;
    word_t protect_hi_q;
    logic protect_en_q;
    prio_t trap_active_q;
    prio_t trap_active_d;
    logic [`WREG_COUNT-1:0] wreg_init_q;
    logic [`SHADOW_DEPTH-1:0] shadow_valid_q;
    word_t live_q;
    index_t cmp_index_q;
    logic cmp_ok_q;
    logic [3:0] pulse_cnt_q;
    logic [3:0] pulse_cnt_d;
    word_t shadow_rd;
    word_t rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // Reset sources

    wire awake = !sleep_mode && !idle_mode;
    wire dog_reset = watchdog_timeout && awake;
    wire dog_wake = watchdog_timeout && !awake;

    // A hard trap that ranks below the hard trap in service
    wire trap_in_hard = is_hard_trap(trap_active_q);
    wire trap_conflict = trap_request && is_hard_trap(trap_priority)
        && trap_in_hard && (trap_priority < trap_active_q);

    // Compare a cycle behind the scan so read data and live data line up
    wire mismatch = cmp_ok_q && shadow_valid_q[cmp_index_q]
        && (shadow_rd != live_q);

    wire illegal_op = fetch_valid
        && (fetch_upper == `ILLEGAL_OPCODE_UPPER);

    // The stack pointer is the top index and is never tracked
    wire ptr_is_wreg = (wreg_pointer_index < index_t'(`WREG_COUNT));
    wire uninit_use = wreg_pointer_use && ptr_is_wreg
        && !wreg_init_q[wreg_pointer_index[3:0]];

    // Entry at the segment base stays legal; the rest is restricted
    wire in_segment = (flow_target > protect_lo_q)
        && (flow_target <= protect_hi_q);
    wire flow_any = program_flow_change || vector_flow_change;
    wire security_hit = protect_en_q && flow_any && in_segment;

    wire illegal_cond = illegal_op || uninit_use || security_hit;

    wire sw_reset = software_reset_instruction;
    wire supply_reset = power_on_event || brownout_event;
    wire any_cause = dog_reset || trap_conflict || mismatch
        || illegal_cond || sw_reset;

    ////////////////////////////////////////////////////////////////////////
    // Register port decode

    wire wr_status = reg_write && reg_hit(reg_addr, `OFS_CAUSE_STATUS);
    wire wr_lo = reg_write && reg_hit(reg_addr, `OFS_PROTECT_LO);
    wire wr_hi = reg_write && reg_hit(reg_addr, `OFS_PROTECT_HI);
    wire wr_ctrl = reg_write && reg_hit(reg_addr, `OFS_PROTECT_CTRL);

    assign rdata_d =
        reg_hit(reg_addr, `OFS_CAUSE_STATUS) ? cause_q :
        reg_hit(reg_addr, `OFS_PROTECT_LO) ? protect_lo_q :
        reg_hit(reg_addr, `OFS_PROTECT_HI) ? protect_hi_q :
        reg_hit(reg_addr, `OFS_PROTECT_CTRL) ? {15'h0000, protect_en_q} :
        16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Reset-cause flags

    // Events build a set mask; it is ORed last so a set beats any clear
    word_t set_mask;
    word_t clr_mask;
    word_t base;
    always_comb begin
        set_mask = 16'h0000;
        set_mask[`BIT_WATCHDOG_TIMEOUT] = watchdog_timeout;
        set_mask[`BIT_TRAP_CONFLICT] = trap_conflict;
        set_mask[`BIT_CONFIG_MISMATCH] = mismatch;
        set_mask[`BIT_ILLEGAL_COND] = illegal_cond;
        set_mask[`BIT_SOFTWARE_RESET] = sw_reset;
        set_mask[`BIT_EXTERNAL_PIN] = external_pin_event;
        set_mask[`BIT_SLEEP] = power_save_instruction && power_save_sleep;
        set_mask[`BIT_IDLE] = power_save_instruction && !power_save_sleep;
        set_mask[`BIT_BROWNOUT] = supply_reset;
        set_mask[`BIT_POWER_ON] = power_on_event;
        clr_mask = 16'h0000;
        if (power_on_event) begin
            clr_mask = `CAUSE_POR_CLEAR_MASK;
        end else if (brownout_event) begin
            clr_mask = `CAUSE_BROWNOUT_CLEAR_MASK;
        end
        clr_mask[`BIT_WATCHDOG_TIMEOUT] = supply_reset
            || power_save_instruction
            || watchdog_clear_instruction;
        base = wr_status ? reg_wdata : cause_q;
        cause_d = ((base & ~clr_mask) | set_mask) & `CAUSE_IMPL_MASK;
    end

    // Flags change through rst, events and register writes, never system reset
    always_ff @(posedge clk) begin
        if (rst) begin
            cause_q <= `CAUSE_RESET_VALUE;
        end else begin
            cause_q <= cause_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Protected segment bounds

    always_ff @(posedge clk) begin
        if (rst) begin
            protect_lo_q <= `PROTECT_LO_RESET;
            protect_hi_q <= `PROTECT_HI_RESET;
            protect_en_q <= 1'b0;
        end else begin
            if (wr_lo) begin
                protect_lo_q <= reg_wdata;
            end
            if (wr_hi) begin
                protect_hi_q <= reg_wdata;
            end
            if (wr_ctrl) begin
                protect_en_q <= reg_wdata[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Hard trap in service

    always_comb begin
        trap_active_d = trap_active_q;
        if (trap_return) begin
            trap_active_d = `TRAP_NONE;
        end
        if (trap_request && !trap_conflict
            && is_hard_trap(trap_priority)
            && trap_priority > trap_active_d) begin
            trap_active_d = trap_priority;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || system_reset_q) begin
            trap_active_q <= `TRAP_NONE;
        end else begin
            trap_active_q <= trap_active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Working register initialisation

    // Cleared on every reset; a write in the reset cycle is dropped
    always_ff @(posedge clk) begin
        if (rst || system_reset_q) begin
            wreg_init_q <= '0;
        end else if (wreg_write
            && wreg_write_index < index_t'(`WREG_COUNT)) begin
            wreg_init_q[wreg_write_index] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin-select shadow scan

    shadow_store u_shadow (
        .clk(clk),
        .wr_en(pps_write),
        .wr_index(pps_index),
        .wr_data(pps_wdata),
        .rd_index(pps_scan_index_q),
        .rd_data_q(shadow_rd)
    );

    // A write to the entry under scan skips one compare, since shadow and
    // live copy change on the same edge and could disagree for a cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pps_scan_index_q <= 4'h0;
            shadow_valid_q <= '0;
            live_q <= 16'h0000;
            cmp_index_q <= 4'h0;
            cmp_ok_q <= 1'b0;
        end else begin
            pps_scan_index_q <= pps_scan_index_q + 4'h1;
            if (pps_write) begin
                shadow_valid_q[pps_index] <= 1'b1;
            end
            live_q <= pps_live_data;
            cmp_index_q <= pps_scan_index_q;
            cmp_ok_q <= !(pps_write && pps_index == pps_scan_index_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System reset and wake outputs

    // Registered, so the reset lands on the next edge; clock is untouched
    always_comb begin
        pulse_cnt_d = pulse_cnt_q;
        if (any_cause) begin
            pulse_cnt_d = `RESET_PULSE_CYCLES;
        end else if (pulse_cnt_q != 4'h0) begin
            pulse_cnt_d = pulse_cnt_q - 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_cnt_q <= 4'h0;
            system_reset_q <= 1'b0;
            watchdog_wake_q <= 1'b0;
            reg_rdata_q <= 16'h0000;
        end else begin
            pulse_cnt_q <= pulse_cnt_d;
            system_reset_q <= (pulse_cnt_d != 4'h0);
            watchdog_wake_q <= dog_wake;
            reg_rdata_q <= reg_read ? rdata_d : 16'h0000;
        end
    end

endmodule

/* reset_cause_logger_sva.sv */
`timescale 1ns/100ps
module reset_cause_checker
    import reset_cause_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Events
    input wire logic brownout_event,
    input wire logic watchdog_timeout,
    input wire logic sleep_mode,
    input wire logic idle_mode,
    input wire logic software_reset_instruction,
    input wire logic trap_request,
    input wire prio_t trap_priority,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_upper,
    // Register port and core outputs
    input wire index_t reg_addr,
    input wire logic reg_read,
    input wire word_t reg_rdata_q,
    input wire logic system_reset_q,
    input wire logic watchdog_wake_q
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence s_rd;
        reg_read && reg_addr == 4'h0;
    endsequence
    sequence s_bad_op;
        fetch_valid && fetch_upper == 8'h3F;
    endsequence
    sequence s_trap(p);
        trap_request && trap_priority == p;
    endsequence
    property p_dog_reset;
        watchdog_timeout && !sleep_mode && !idle_mode |=> system_reset_q;
    endproperty
    a_dog_reset: assert property (p_dog_reset)
        else $error("watchdog reset missing");
    property p_dog_wake;
        watchdog_timeout && (sleep_mode || idle_mode) |=> watchdog_wake_q;
    endproperty
    a_dog_wake: assert property (p_dog_wake)
        else $error("wake missing");
    property p_dog_flag;
        watchdog_timeout ##2 s_rd |=> reg_rdata_q[4];
    endproperty
    a_dog_flag: assert property (p_dog_flag)
        else $error("watchdog flag not set");
    // Two hard traps two cycles apart: the first is still in service
    property p_trap;
        s_trap(4'hE) ##2 s_trap(4'hD) |=> system_reset_q;
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap conflict reset missing");
    property p_opcode;
        s_bad_op |=> system_reset_q;
    endproperty
    a_opcode: assert property (p_opcode)
        else $error("illegal opcode reset missing");
    property p_ill_flag;
        s_bad_op ##2 s_rd |=> reg_rdata_q[14];
    endproperty
    a_ill_flag: assert property (p_ill_flag)
        else $error("illegal flag not kept");
    property p_soft;
        software_reset_instruction |=> system_reset_q ##1 !system_reset_q;
    endproperty
    a_soft: assert property (p_soft)
        else $error("software reset pulse wrong");
    property p_brown;
        brownout_event ##2 s_rd |=> reg_rdata_q[1] && !reg_rdata_q[14];
    endproperty
    a_brown: assert property (p_brown)
        else $error("brown-out flags wrong");
endmodule
bind reset_cause_logger reset_cause_checker u_chk (
    .clk, .rst, .brownout_event, .watchdog_timeout, .sleep_mode,
    .idle_mode, .software_reset_instruction, .trap_request,
    .trap_priority, .fetch_valid, .fetch_upper, .reg_addr, .reg_read,
    .reg_rdata_q, .system_reset_q, .watchdog_wake_q
);

/* pin_select_model.sv */
`timescale 1ns/100ps
module pin_select_model
    import reset_cause_pkg::*;
(
    // Clock
    input wire logic clk,
    // Writes from the core
    input wire logic pps_write,
    input wire index_t pps_index,
    input wire word_t pps_wdata,
    // Scan port and commanded upset
    input wire index_t pps_scan_index_q,
    input wire word_t upset,
    output word_t pps_live_data
);
    word_t cells [16];
    initial begin
        foreach (cells[i]) begin
            cells[i] = 16'h0000;
        end
    end
    always @(posedge clk) begin
        if (pps_write) begin
            cells[pps_index] <= pps_wdata;
        end
    end
    // Upset flips the live read of the cell as a disturbance would, shadow untouched
    assign pps_live_data = cells[pps_scan_index_q] ^ upset;
endmodule

/* testbench.sv */
`timescale 1ns/100ps
module testbench
    import reset_cause_pkg::*;
;
    localparam int PWR_ON = 0, BROWN = 1, DOG = 3, SAVE = 4, DOG_CLR = 5;
    localparam int SOFT = 6, TRAP = 7, TRAP_RET = 8, FETCH = 9, W_WR = 10;
    localparam int W_PTR = 11, PROG = 12, VECT = 13, PIN_WR = 14;
    localparam int EXT_PIN = 2;
    logic clk = 1'b0, rst = 1'b1, sleep_mode = 1'b0, idle_mode = 1'b0;
    logic reg_write = 1'b0, reg_read = 1'b0;
    logic system_reset_q, watchdog_wake_q;
    logic [14:0] ev = '0;
    index_t reg_addr = 4'h0;
    index_t scan;
    word_t reg_wdata = 16'h0000, arg = 16'h0000, upset = 16'h0000;
    word_t reg_rdata_q, live;
    int error_cnt = 0, checked = 0;
    // One argument word feeds every qualifier; only the pulsed event reads it
    reset_cause_logger dut (
        .clk, .rst, .power_on_event(ev[0]), .brownout_event(ev[1]),
        .external_pin_event(ev[2]), .watchdog_timeout(ev[3]),
        .sleep_mode, .idle_mode, .power_save_instruction(ev[4]),
        .power_save_sleep(arg[0]), .watchdog_clear_instruction(ev[5]),
        .software_reset_instruction(ev[6]), .trap_request(ev[7]),
        .trap_priority(arg[3:0]), .trap_return(ev[8]),
        .pps_write(ev[14]), .pps_index(arg[3:0]), .pps_wdata(arg),
        .pps_live_data(live), .fetch_valid(ev[9]),
        .fetch_upper(arg[7:0]), .wreg_write(ev[10]),
        .wreg_write_index(arg[3:0]), .wreg_pointer_use(ev[11]),
        .wreg_pointer_index(arg[3:0]), .program_flow_change(ev[12]),
        .vector_flow_change(ev[13]), .flow_target(arg), .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata_q,
        .system_reset_q, .watchdog_wake_q, .pps_scan_index_q(scan));
    pin_select_model far (.clk, .pps_write(ev[14]), .pps_index(arg[3:0]),
        .pps_wdata(arg), .pps_scan_index_q(scan), .upset,
        .pps_live_data(live));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input word_t seen, word_t exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic pulse(input int b, input word_t a);
        @(posedge clk);
        arg <= a;
        ev <= 15'h0001 << b;
        @(posedge clk);
        ev <= '0;
        #1;
    endtask
    task automatic fire(input int b, input logic r, input word_t a);
        pulse(b, a);
        chk("system reset", 16'(system_reset_q), 16'(r));
    endtask
    task automatic wr(input index_t a, input word_t d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input index_t a, input word_t exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk("register", reg_rdata_q, exp);
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic t_flags;
        rd(4'h0, 16'h0003);
        @(posedge clk);
        #1;
        chk("read idle", reg_rdata_q, 16'h0000);
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hC2DF);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, 16'h0000);
        pulse(BROWN, 16'h0000);
        rd(4'h0, 16'h0083);
        pulse(PWR_ON, 16'h0000);
        rd(4'h0, 16'h0003);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0000);
        $display("flag test done");
    endtask
    task automatic t_dog;
        fire(DOG, 1'b1, 16'h0000);
        rd(4'h0, 16'h0010);
        fire(DOG_CLR, 1'b0, 16'h0000);
        rd(4'h0, 16'h0000);
        @(posedge clk);
        sleep_mode <= 1'b1;
        fire(DOG, 1'b0, 16'h0000);
        chk("wake", 16'(watchdog_wake_q), 16'h0001);
        rd(4'h0, 16'h0010);
        @(posedge clk);
        sleep_mode <= 1'b0;
        idle_mode <= 1'b1;
        fire(DOG, 1'b0, 16'h0000);
        chk("wake", 16'(watchdog_wake_q), 16'h0001);
        @(posedge clk);
        idle_mode <= 1'b0;
        fire(SAVE, 1'b0, 16'h0000);
        rd(4'h0, 16'h0004);
        fire(DOG, 1'b1, 16'h0000);
        fire(SAVE, 1'b0, 16'h0001);
        rd(4'h0, 16'h000C);
        pulse(EXT_PIN, 16'h0000);
        rd(4'h0, 16'h008C);
        wr(4'h0, 16'h0000);
        $display("watchdog test done");
    endtask
    task automatic t_trap;
        fire(TRAP, 1'b0, 16'h000E);
        fire(TRAP, 1'b1, 16'h000D);
        rd(4'h0, 16'h8000);
        fire(TRAP, 1'b0, 16'h000D);
        fire(TRAP, 1'b0, 16'h000E);
        fire(TRAP_RET, 1'b0, 16'h0000);
        fire(TRAP_RET, 1'b0, 16'h0000);
        fire(TRAP, 1'b0, 16'h000F);
        fire(TRAP, 1'b0, 16'h000C);
        fire(TRAP, 1'b1, 16'h000E);
        wr(4'h0, 16'h0000);
        $display("trap test done");
    endtask
    task automatic t_ill;
        fire(FETCH, 1'b0, 16'h003E);
        fire(FETCH, 1'b1, 16'h003F);
        rd(4'h0, 16'h4000);
        fire(SOFT, 1'b1, 16'h0000);
        rd(4'h0, 16'h4040);
        fire(W_WR, 1'b0, 16'h0003);
        fire(W_PTR, 1'b0, 16'h0003);
        fire(W_PTR, 1'b0, 16'h000F);
        fire(W_PTR, 1'b1, 16'h0004);
        fire(W_PTR, 1'b1, 16'h0003);
        wr(4'h0, 16'h0000);
        wr(4'h1, 16'h0100);
        wr(4'h2, 16'h0200);
        wr(4'h3, 16'h0001);
        rd(4'h1, 16'h0100);
        fire(PROG, 1'b0, 16'h0100);
        fire(PROG, 1'b1, 16'h0101);
        fire(VECT, 1'b1, 16'h0200);
        fire(VECT, 1'b0, 16'h0201);
        rd(4'h0, 16'h4000);
        wr(4'h3, 16'h0000);
        fire(PROG, 1'b0, 16'h0150);
        wr(4'h0, 16'h0000);
        $display("illegal condition test done");
    endtask
    task automatic t_pin;
        int n;
        index_t step;
        fire(PIN_WR, 1'b0, 16'h0002);
        n = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            n += system_reset_q;
        end
        chk("quiet scan", 16'(n), 16'h0000);
        step = scan + 4'h1;
        @(posedge clk);
        #1;
        chk("scan index", 16'(scan), 16'(step));
        @(posedge clk);
        upset <= 16'h0100;
        n = 0;
        while (!system_reset_q && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("mismatch", 16'(system_reset_q), 16'h0001);
        @(posedge clk);
        upset <= 16'h0000;
        rd(4'h0, 16'h0200);
        $display("pin select test done");
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        forever begin
            #25;
            clk = ~clk;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_flags();
        t_dog();
        t_trap();
        t_ill();
        t_pin();
        results();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        results();
    end
endmodule
